// *** pkg/i2cdst_cfg.svh ***
// Offsets, field positions, reset values and widths of the disable status tracker.
// Assumes inclusion by bare name from design files that also import i2cdst_pkg.
`ifndef I2CDST_CFG_SVH
`define I2CDST_CFG_SVH

// ==========================================================
// Register offsets (byte addresses)
`define I2CDST_OFS_STATUS    8'h9c
`define I2CDST_OFS_IRQ_STAT  8'hb0
`define I2CDST_OFS_IRQ_MASK  8'hb4

// ==========================================================
// Field positions of enable_abort_status
`define I2CDST_BIT_ENABLE    0
`define I2CDST_BIT_BUSYOFF   1
`define I2CDST_BIT_LOST      2

// ==========================================================
// Event bits of the interrupt status and mask registers
`define I2CDST_EVT_BUSYOFF   0
`define I2CDST_EVT_LOST      1
`define I2CDST_EVT_OFF       2
`define I2CDST_EVT_W         3

// ==========================================================
// Reset values
`define I2CDST_RST_STATUS    32'h0000_0000
`define I2CDST_RST_MASK      3'h0

`endif

// *** pkg/i2cdst_pkg.sv ***
// Types shared by the disable status tracker modules.
// Assumes nothing beyond a SystemVerilog compiler.
package i2cdst_pkg;

    // ==========================================================
    // Status strobes from the controller core, synchronous to clk
    typedef struct packed {
        logic slv_tx_addr;   // Pulse: address for a slave transmit received
        logic slv_rx_addr;   // Pulse: own address matched for a slave receive
        logic slv_rx_data;   // Pulse: data byte arrived in slave receive
        logic start_det;     // Pulse: START seen on the bus
        logic stop_det;      // Pulse: STOP seen on the bus
        logic mst_active;    // Level: core is acting as master
        logic core_idle;     // Level: core has no transfer in flight
    } i2cdst_core_s;

    // ==========================================================
    // Register port
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } i2cdst_bus_s;

    // ==========================================================
    // Enable sequencing
    typedef enum logic [1:0] {
        EN_OFF   = 2'b00,
        EN_ON    = 2'b01,
        EN_DRAIN = 2'b10
    } i2cdst_en_e;

endpackage : i2cdst_pkg

// *** src/i2cdst_abort.sv ***
// Tracks slave engagement and captures the abort flags at the disable moment.
// Assumes core strobes are clean single-cycle pulses synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "i2cdst_cfg.svh"

module i2cdst_abort
    import i2cdst_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // Core view and enable events
    input  wire i2cdst_core_s core,
    input  wire logic         disable_evt,
    input  wire logic         enable_evt,
    // Results
    output logic              engaged,
    output logic              busy_off_r,
    output logic              data_lost_r
);

    // ==========================================================
    // Engagement latches
    logic tx_r;
    logic rx_addr_r;
    logic data_r;

    // Latches survive STOP so an abandoned transfer still counts
    wire logic restart  = core.start_det | disable_evt;
    wire logic tx_nxt   = core.slv_tx_addr | (tx_r & ~restart);
    wire logic rxa_nxt  = core.slv_rx_addr | (rx_addr_r & ~restart);
    wire logic data_set = core.slv_rx_data & (rx_addr_r | core.slv_rx_addr);
    wire logic data_nxt = data_set | (data_r & ~restart);

    assign engaged = tx_r | data_r;

    // Flags move only at disable or re-enable, so reads stay steady between
    wire logic busy_off_nxt  = disable_evt ? (engaged & ~core.mst_active) :
                               enable_evt  ? 1'b0 : busy_off_r;
    wire logic data_lost_nxt = disable_evt ? data_r :
                               enable_evt  ? 1'b0 : data_lost_r;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tx_r      <= 1'b0;
            rx_addr_r <= 1'b0;
            data_r    <= 1'b0;
            busy_off_r  <= 1'b0;
            data_lost_r <= 1'b0;
        end
        else
        begin
            tx_r      <= tx_nxt;
            rx_addr_r <= rxa_nxt;
            data_r    <= data_nxt;
            busy_off_r  <= busy_off_nxt;
            data_lost_r <= data_lost_nxt;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence tx_abandoned_s;
        core.slv_tx_addr && !core.start_det ##1 core.stop_det && !core.start_det;
    endsequence
    sequence rx_stopped_s;
        core.slv_rx_addr ##1 core.slv_rx_data && !core.start_det ##1 core.stop_det && !core.start_det;
    endsequence

    abandon_sets_a: assert property ((tx_abandoned_s or rx_stopped_s) ##1 !core.start_det
                                     ##1 (disable_evt && !core.mst_active) |=> busy_off_r)
        else $error("abandoned slave transfer did not set busy flag");
    stop_lost_a: assert property (rx_stopped_s ##1 !core.start_det ##1 disable_evt |=> data_lost_r)
        else $error("stopped receive did not set data lost flag");
    clean_disable_a: assert property (disable_evt && (!engaged || core.mst_active) |=> !busy_off_r)
        else $error("busy flag set on a clean disable");
    no_data_a: assert property (disable_evt && !data_r |=> !data_lost_r)
        else $error("data lost flag set without a data phase");

endmodule : i2cdst_abort

`default_nettype wire

// *** src/i2cdst_irq.sv ***
// Sticky event status with write-one-to-clear, a mask and one level interrupt.
// Assumes events and clears are one-cycle pulses in the clk domain.
`timescale 1ns/1ps
`default_nettype none
`include "i2cdst_cfg.svh"

module i2cdst_irq
    import i2cdst_pkg::*;
#(
    parameter int W = `I2CDST_EVT_W
)
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // Events and software access
    input  wire logic [W-1:0] evt,
    input  wire logic [W-1:0] clr,
    input  wire logic         mask_wr,
    input  wire logic [W-1:0] mask_wdata,
    // State
    output logic      [W-1:0] stat_r,
    output logic      [W-1:0] mask_r,
    output logic              irq_r
);

    // ==========================================================
    // Next values; a set in the clear cycle wins
    wire logic [W-1:0] stat_nxt = evt | (stat_r & ~clr);
    wire logic [W-1:0] mask_nxt = mask_wr ? mask_wdata : mask_r;
    wire logic         irq_nxt  = |(stat_nxt & mask_nxt);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            stat_r <= '0;
            mask_r <= `I2CDST_RST_MASK;
            irq_r  <= 1'b0;
        end
        else
        begin
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            irq_r  <= irq_nxt;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    set_beats_clr_a: assert property ((evt & clr) != '0 |=> (stat_r & $past(evt & clr)) == $past(evt & clr))
        else $error("event lost to a same-cycle clear");
    irq_level_a: assert property (|(stat_r & mask_r) |-> irq_r)
        else $error("unmasked status without interrupt");

endmodule : i2cdst_irq

`default_nettype wire

// *** src/i2cdst_top.sv ***
// Disable status tracker: effective enable, abort flags and their register port.
// Assumes the control enable bit and core strobes are synchronous to clk.
//
// What this block does
// - Status bit 0 shows the enable level actually driven to the core.
// - Clearing enable during a slave transmit, or a slave receive with data arrived, sets the busy-disable flag.
// - A busy disable forces NACK only for an engaged (transmit addressed, or receive with data arrived) slave transfer, not an unmatched one.
// - A transfer the master abandoned before our NACK still sets the busy flag.
// - Disabling as master or with no slave transfer engaged leaves the busy flag clear.
// - Aborting a matched slave receive with data arrived sets bit 2.
// - A STOP before our NACK, then disable, also sets bit 2.
// - Bit 2 stays clear if no slave receive data phase took part.
`timescale 1ns/1ps
`default_nettype none
`include "i2cdst_cfg.svh"

module i2cdst_top
    import i2cdst_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // Register port
    input  wire i2cdst_bus_s  bus,
    output logic [31:0]       reg_rdata,
    // Control enable bit as written by software
    input  wire logic         ctrl_enable,
    // Controller core
    input  wire i2cdst_core_s core,
    output logic              core_enable,
    output logic              force_nack,
    // Interrupt
    output logic              irq
);

    // ==========================================================
    // Enable sequencing
    i2cdst_en_e  state_r;
    i2cdst_en_e  state_nxt;
    logic        core_enable_r;
    logic        force_nack_r;
    logic [31:0] rdata_r;

    wire logic engaged;
    wire logic busy_off_r;
    wire logic data_lost_r;

    // Disable is taken at the first cycle software drops enable
    wire logic disable_evt = (state_r == EN_ON) && !ctrl_enable;
    wire logic enable_evt  = (state_r == EN_OFF) && ctrl_enable;
    wire logic drain_done  = (state_r == EN_DRAIN) && core.core_idle;
    wire logic off_evt     = (disable_evt && core.core_idle) || drain_done;

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            EN_OFF:
            begin
                if (ctrl_enable)
                    state_nxt = EN_ON;
            end
            EN_ON:
            begin
                // Core keeps running until its transfer is wound down
                if (!ctrl_enable)
                    state_nxt = core.core_idle ? EN_OFF : EN_DRAIN;
            end
            EN_DRAIN:
            begin
                if (core.core_idle)
                    state_nxt = EN_OFF;
            end
            default:
                state_nxt = EN_OFF;
        endcase
    end

    // Enable re-asserted during drain waits for the drain to finish first
    wire logic enable_nxt = (state_nxt != EN_OFF);
    // NACK is forced only for an engaged transfer while the core is not idle
    wire logic nack_set   = disable_evt && engaged && !core.core_idle;
    wire logic nack_nxt   = nack_set || (force_nack_r && !drain_done);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_r       <= EN_OFF;
            core_enable_r <= 1'b0;
            force_nack_r  <= 1'b0;
        end
        else
        begin
            state_r       <= state_nxt;
            core_enable_r <= enable_nxt;
            force_nack_r  <= nack_nxt;
        end
    end

    assign core_enable = core_enable_r;
    assign force_nack  = force_nack_r;

    // ==========================================================
    // Abort flag capture
    i2cdst_abort u_abort (
        .clk         (clk),
        .reset       (reset),
        .core        (core),
        .disable_evt (disable_evt),
        .enable_evt  (enable_evt),
        .engaged     (engaged),
        .busy_off_r  (busy_off_r),
        .data_lost_r (data_lost_r)
    );

    // ==========================================================
    // Address decode
    wire logic hit_status = (bus.addr == `I2CDST_OFS_STATUS);
    wire logic hit_istat  = (bus.addr == `I2CDST_OFS_IRQ_STAT);
    wire logic hit_imask  = (bus.addr == `I2CDST_OFS_IRQ_MASK);

    wire logic                     istat_wr = bus.wr && hit_istat;
    wire logic                     imask_wr = bus.wr && hit_imask;
    wire logic [`I2CDST_EVT_W-1:0] wr_bits  = bus.wdata[`I2CDST_EVT_W-1:0];

    // ==========================================================
    // Interrupt events
    wire logic [`I2CDST_EVT_W-1:0] irq_evt;
    wire logic [`I2CDST_EVT_W-1:0] irq_clr;
    wire logic [`I2CDST_EVT_W-1:0] irq_stat;
    wire logic [`I2CDST_EVT_W-1:0] irq_mask;

    assign irq_evt[`I2CDST_EVT_BUSYOFF] = disable_evt && engaged && !core.mst_active;
    assign irq_evt[`I2CDST_EVT_LOST]    = disable_evt && u_abort.data_r;
    assign irq_evt[`I2CDST_EVT_OFF]  = off_evt;
    assign irq_clr                   = istat_wr ? wr_bits : '0;

    i2cdst_irq #(
        .W (`I2CDST_EVT_W)
    ) u_irq (
        .clk        (clk),
        .reset      (reset),
        .evt        (irq_evt),
        .clr        (irq_clr),
        .mask_wr    (imask_wr),
        .mask_wdata (wr_bits),
        .stat_r     (irq_stat),
        .mask_r     (irq_mask),
        .irq_r      (irq)
    );

    // ==========================================================
    // Read path
    function automatic logic [31:0] pad_word(input logic [`I2CDST_EVT_W-1:0] v);
        logic [31:0] w;
        w = `I2CDST_RST_STATUS;
        w[`I2CDST_EVT_W-1:0] = v;
        return w;
    endfunction : pad_word

    // Abort flags may be transient while enabled; software waits for bit 0 low
    logic [31:0] status_word;
    always_comb
    begin
        status_word                    = `I2CDST_RST_STATUS;
        status_word[`I2CDST_BIT_ENABLE] = core_enable_r;
        status_word[`I2CDST_BIT_BUSYOFF] = busy_off_r;
        status_word[`I2CDST_BIT_LOST]    = data_lost_r;
    end

    // Status has no write path at all, so writes there fall away
    wire logic [31:0] rd_word = hit_status ? status_word :
                                hit_istat  ? pad_word(irq_stat) :
                                hit_imask  ? pad_word(irq_mask) : 32'h0000_0000;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            rdata_r <= 32'h0000_0000;
        else
            rdata_r <= bus.rd ? rd_word : 32'h0000_0000;
    end

    assign reg_rdata = rdata_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence busy_disable_s;
        state_r == EN_ON && !ctrl_enable && engaged && !core.core_idle;
    endsequence

    en_readback_a: assert property (bus.rd && hit_status |=> reg_rdata[0] == $past(core_enable_r))
        else $error("status bit 0 differs from driven enable");
    en_follows_a: assert property (state_r == EN_DRAIN |-> core_enable_r)
        else $error("core enable dropped before drain ended");
    busy_flag_a: assert property (disable_evt && engaged && !core.mst_active |=> busy_off_r)
        else $error("busy disable did not set flag");
    nack_forced_a: assert property (busy_disable_s |=> force_nack_r && core_enable_r)
        else $error("busy disable did not force nack");
    nack_ends_a: assert property (force_nack_r && core.core_idle |=> !force_nack_r ##1 !force_nack_r)
        else $error("forced nack outlived the drain");
    data_lost_a: assert property (disable_evt && u_abort.data_r |=> data_lost_r)
        else $error("aborted receive did not set data lost");
    upper_zero_a: assert property (bus.rd && hit_status |=> reg_rdata[31:3] == 29'h0)
        else $error("reserved status bits not zero");
    status_ro_a: assert property (bus.wr && hit_status && !disable_evt && !enable_evt
                                  |=> $stable(busy_off_r) && $stable(data_lost_r))
        else $error("status write altered a flag");
    rd_one_cycle_a: assert property (!bus.rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");

endmodule : i2cdst_top

`default_nettype wire

// *** tb/i2cdst_core_model.sv ***
// Controller core as seen when a remote master addresses us, or we act as master.
// Assumes go and fin are one-cycle pulses from the bench, driven after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module i2cdst_core_model
    import i2cdst_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // Bench control
    input  wire logic [2:0]   kind,
    input  wire logic         go,
    input  wire logic         fin,
    // Core strobes
    output var  i2cdst_core_s core
);
    // ==========================================================
    // Kinds: 0 idle, 1 master, 2 slave tx, 3 slave rx data, 4 abandoned, 5 address then START
    logic [1:0] step_r;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            core           <= '0;
            core.core_idle <= 1'b1;
            step_r         <= 2'h0;
        end
        else
        begin
            core.slv_tx_addr <= 1'b0;
            core.slv_rx_addr <= 1'b0;
            core.slv_rx_data <= 1'b0;
            core.start_det   <= 1'b0;
            core.stop_det    <= 1'b0;
            if (go)
            begin
                step_r          <= 2'h1;
                core.start_det  <= 1'b1;
                core.core_idle  <= 1'b0;
                core.mst_active <= (kind == 3'h1);
            end
            else if (step_r == 2'h1)
            begin
                step_r           <= 2'h2;
                core.slv_tx_addr <= (kind == 3'h2);
                core.slv_rx_addr <= (kind >= 3'h3);
            end
            else if (step_r == 2'h2)
            begin
                step_r           <= 2'h3;
                core.slv_rx_data <= (kind == 3'h3) || (kind == 3'h4);
                core.start_det   <= (kind == 3'h5);
            end
            else if (step_r == 2'h3)
            begin
                // Abandoned transfer: STOP before any NACK, bus goes idle at once
                step_r         <= 2'h0;
                core.stop_det  <= (kind == 3'h4);
                core.core_idle <= (kind == 3'h0) || (kind == 3'h4);
            end
            else if (fin)
            begin
                // Drain ends only when the bench says so, to hold the core busy
                core.core_idle  <= 1'b1;
                core.mst_active <= 1'b0;
            end
        end
    end
endmodule : i2cdst_core_model

`default_nettype wire

// *** tb/i2cdst_tb_top.sv ***
// Self-checking bench of the disable status tracker over its register port.
// Assumes the core model stands in for the controller core and remote master.
`timescale 1ns/1ps
`default_nettype none
`include "i2cdst_cfg.svh"

module i2cdst_tb_top;
    import i2cdst_pkg::*;

    // ==========================================================
    // Signals
    logic         clk;
    logic         reset;
    i2cdst_bus_s  bus;
    logic [31:0]  reg_rdata;
    logic         ctrl_enable;
    i2cdst_core_s core;
    logic         core_enable;
    logic         force_nack;
    logic         irq;
    logic [2:0]   kind;
    logic         go;
    logic         fin;
    int           failures;
    int           tests_run;

    i2cdst_top i2cdst_top_inst (.clk(clk), .reset(reset), .bus(bus), .reg_rdata(reg_rdata),
        .ctrl_enable(ctrl_enable), .core(core), .core_enable(core_enable),
        .force_nack(force_nack), .irq(irq));
    i2cdst_core_model i2cdst_core_model_inst (.clk(clk), .reset(reset), .kind(kind),
        .go(go), .fin(fin), .core(core));

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge clk);
        bus.wr    <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clk);
        bus.rd   <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
        @(posedge clk);
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp, msg);
    endtask : rchk

    // One enable, transfer, disable and drain; flags trusted only once bit 0 reads 0
    task automatic play(input logic [2:0] k, input logic [31:0] est, input logic en, input logic [31:0] eirq);
        logic [31:0] d;
        logic        busy;
        busy = !((k == 3'h0) || (k == 3'h4));
        wr(`I2CDST_OFS_IRQ_STAT, 32'h0000_0007);
        ctrl_enable <= 1'b1;
        repeat (2) @(posedge clk);
        rchk(`I2CDST_OFS_STATUS, 32'h0000_0001, "enabled, flags clear");
        wr(`I2CDST_OFS_STATUS, 32'hffff_fffe);
        rchk(`I2CDST_OFS_STATUS, 32'h0000_0001, "status write ignored");
        kind <= k;
        go   <= 1'b1;
        @(posedge clk);
        go   <= 1'b0;
        repeat (5) @(posedge clk);
        ctrl_enable <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk) chk({31'h0, force_nack}, {31'h0, en}, "forced nack");
        chk({31'h0, core_enable}, {31'h0, busy}, "enable while draining");
        @(posedge clk);
        rd(`I2CDST_OFS_STATUS, d);
        chk({31'h0, d[0]}, {31'h0, busy}, "status bit 0 while draining");
        fin <= 1'b1;
        @(posedge clk);
        fin <= 1'b0;
        for (int i = 0; i < 8 && d[0] !== 1'b0; i++) rd(`I2CDST_OFS_STATUS, d);
        chk(d, est, "status after drain");
        @(negedge clk) chk({31'h0, force_nack}, 32'h0, "nack released");
        @(posedge clk);
        rchk(`I2CDST_OFS_IRQ_STAT, eirq, "event status");
        $display("test of kind %0d done", k);
    endtask : play

    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    // ==========================================================
    // Sequence
    initial
    begin
        failures    = 0;
        tests_run   = 0;
        reset       = 1'b1;
        bus         = '0;
        ctrl_enable = 1'b0;
        kind        = 3'h0;
        go          = 1'b0;
        fin         = 1'b0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rchk(`I2CDST_OFS_STATUS, `I2CDST_RST_STATUS, "status reset");
        rchk(`I2CDST_OFS_IRQ_MASK, 32'h0, "mask reset");
        wr(8'h40, 32'hffff_ffff);
        rchk(8'h40, 32'h0, "unmapped read");
        chk({31'h0, irq}, 32'h0, "irq at reset");
        $display("reset test done");
        play(3'h0, 32'h0, 1'b0, 32'h4);
        play(3'h1, 32'h0, 1'b0, 32'h4);
        play(3'h2, 32'h2, 1'b1, 32'h5);
        play(3'h5, 32'h0, 1'b0, 32'h4);
        play(3'h3, 32'h6, 1'b1, 32'h7);
        wr(`I2CDST_OFS_IRQ_MASK, 32'h0000_0002);
        rchk(`I2CDST_OFS_IRQ_MASK, 32'h2, "mask readback");
        @(negedge clk) chk({31'h0, irq}, 32'h1, "irq raised");
        @(posedge clk);
        wr(`I2CDST_OFS_IRQ_STAT, 32'h0000_0002);
        @(negedge clk) chk({31'h0, irq}, 32'h0, "irq cleared");
        @(posedge clk);
        rchk(`I2CDST_OFS_IRQ_STAT, 32'h5, "one-to-clear leaves others");
        wr(`I2CDST_OFS_IRQ_MASK, 32'h0);
        $display("interrupt test done");
        play(3'h4, 32'h6, 1'b0, 32'h7);
        stop_test();
    end

    // Whole run is about two hundred cycles; this is twenty times that
    initial
    begin
        #(25 * 4000);
        failures++;
        stop_test();
    end
endmodule : i2cdst_tb_top

`default_nettype wire
